// file: sac_pkg.sv
// shared constants, types and helpers for the sdram command link
package sac_pkg;
	// ----------------------------------------
	// widths and geometry
	// ----------------------------------------
	localparam int ROW_W      = 13;
	localparam int COL_W      = 10;
	localparam int BANK_W     = 3;
	localparam int BANKS      = 8;
	localparam int LANES      = 2;
	localparam int DQ_W       = 16;
	localparam int NUM_MR     = 4;
	localparam int MR_SEL_W   = 2;
	localparam int MEM_AW     = 8;
	localparam int MEM_DEPTH  = 256;
	localparam int FIFO_DEPTH = 4;
	localparam int AP_BIT     = 10;
	localparam int BC_BIT     = 12;
	// ----------------------------------------
	// command codes {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DES = 4'h8;
	localparam logic [2:0] LAST_BL8 = 3'h7;
	localparam logic [2:0] LAST_BC4 = 3'h3;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         CK_PERIOD_NS  = 16;
	localparam int         CK_DIV        = CK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [1:0] PH_RISE       = 2'(CK_DIV - 1);
	localparam logic [1:0] PH_FALL       = 2'(CK_DIV / 2 - 1);
	localparam int         RD_WAIT_NS    = 192;
	localparam logic [3:0] RD_WAIT_CK    = 4'(RD_WAIT_NS / CK_PERIOD_NS);
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WR   = 3'b010,
		ST_RD   = 3'b100
	} sac_st_t;
	typedef enum logic [2:0] {
		OP_NOP = 3'h0,
		OP_ACT = 3'h1,
		OP_RD  = 3'h2,
		OP_WR  = 3'h3,
		OP_PRE = 3'h4,
		OP_MRS = 3'h5,
		OP_REF = 3'h6
	} sac_op_t;
	function automatic logic [2:0] burst_last(input logic chop);
		return chop ? LAST_BC4 : LAST_BL8;
	endfunction
endpackage

// file: sac_link_if.sv
// pin-level link between controller and memory device
`timescale 1ns/10ps
interface sac_link_if;
	import sac_pkg::*;
	logic                ck;
	logic                reset_n;
	logic                cs_n;
	logic                ras_n;
	logic                cas_n;
	logic                we_n;
	logic [BANK_W-1:0]   bank_select;
	logic [ROW_W-1:0]    row_col_address;
	logic [LANES-1:0]    byte_write_masks;
	logic [DQ_W-1:0]     ctl_dq_o;
	logic [DQ_W-1:0]     dev_dq_o;
	logic [LANES-1:0]    ctl_dq_oe;
	logic [LANES-1:0]    dev_dq_oe;
	logic [LANES-1:0]    ctl_dqs_o;
	logic [LANES-1:0]    ctl_dqs_n_o;
	logic [LANES-1:0]    dev_dqs_o;
	logic [LANES-1:0]    dev_dqs_n_o;
	logic [7:0]          low_data_byte;
	logic [7:0]          high_data_byte;
	logic [1:0]          low_byte_strobe_pair;
	logic [1:0]          high_byte_strobe_pair;
	// ----------------------------------------
	// wire resolution, strobe pair is {true, comp}
	// ----------------------------------------
	assign low_data_byte = dev_dq_oe[0] ? dev_dq_o[7:0] :
		(ctl_dq_oe[0] ? ctl_dq_o[7:0] : 8'h00);
	assign high_data_byte = dev_dq_oe[1] ? dev_dq_o[15:8] :
		(ctl_dq_oe[1] ? ctl_dq_o[15:8] : 8'h00);
	assign low_byte_strobe_pair = dev_dq_oe[0] ? {dev_dqs_o[0], dev_dqs_n_o[0]} :
		(ctl_dq_oe[0] ? {ctl_dqs_o[0], ctl_dqs_n_o[0]} : 2'h1);
	assign high_byte_strobe_pair = dev_dq_oe[1] ? {dev_dqs_o[1], dev_dqs_n_o[1]} :
		(ctl_dq_oe[1] ? {ctl_dqs_o[1], ctl_dqs_n_o[1]} : 2'h1);
	modport dev (
		input  ck, reset_n, cs_n, ras_n, cas_n, we_n, bank_select,
		input  row_col_address, byte_write_masks, low_data_byte, high_data_byte,
		input  low_byte_strobe_pair, high_byte_strobe_pair,
		output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_n_o
	);
	modport ctl (
		output ck, reset_n, cs_n, ras_n, cas_n, we_n, bank_select,
		output row_col_address, byte_write_masks, ctl_dq_o, ctl_dq_oe,
		output ctl_dqs_o, ctl_dqs_n_o,
		input  low_data_byte, high_data_byte, low_byte_strobe_pair, high_byte_strobe_pair
	);
endinterface

// file: sac_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module sac_fifo #(
	parameter int W = 18,
	parameter int D = 4
) (
	input  wire logic         clk,       // clock
	input  wire logic         rst_n,     // async reset, active low
	input  wire logic         in_valid,  // write side valid
	output logic              in_ready,  // write side ready
	input  wire logic [W-1:0] in_data,   // write data
	output logic              out_valid, // read side valid
	input  wire logic         out_ready, // read side ready
	output logic [W-1:0]      out_data   // read data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;
	assign in_ready  = cnt_q != (AW+1)'(D);
	assign out_valid = cnt_q != '0;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rp_q];
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(D-1)) ? '0 : AW'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(D-1)) ? '0 : AW'(rp_q + 1'b1);
			end
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end
endmodule

// file: sac_mem_dev.sv
// memory device end: command decode, bank state, small array, strobed data
`timescale 1ns/10ps
module sac_mem_dev
	import sac_pkg::*;
(
	sac_link_if.dev                      link,         // pin side, on link.ck
	output logic [NUM_MR-1:0][ROW_W-1:0] mode_regs,    // stored mode words
	output logic [BANKS-1:0]             bank_open,    // bank holds an open row
	output logic                         burst_busy,   // burst running
	output logic                         cmd_refused,  // pulse: command dropped
	output logic                         strobe_fault  // write strobe misbehaved
);
	// ----------------------------------------
	// input stage
	// ----------------------------------------
	logic [3:0]                   cmd_q;
	logic [BANK_W-1:0]            ba_q;
	logic [ROW_W-1:0]             addr_q;
	logic [LANES-1:0]             mask_q;
	logic [DQ_W-1:0]              wdat_q;
	logic [3:0]                   cmd;
	logic [LANES-1:0]             wstb_t_q;
	logic [LANES-1:0]             wstb_c_q;
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			cmd_q  <= CMD_DES;
			ba_q   <= '0;
			addr_q <= '0;
			mask_q <= '1;
			wdat_q <= '0;
		end else begin
			cmd_q  <= {link.cs_n, link.ras_n, link.cas_n, link.we_n};
			ba_q   <= link.bank_select;
			addr_q <= link.row_col_address;
			mask_q <= link.byte_write_masks;
			wdat_q <= {link.high_data_byte, link.low_data_byte};
		end
	end
	// write strobe sampled mid-cycle, away from its own edges
	always_ff @(negedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			wstb_t_q <= '0;
			wstb_c_q <= '1;
		end else begin
			wstb_t_q <= {link.high_byte_strobe_pair[1], link.low_byte_strobe_pair[1]};
			wstb_c_q <= {link.high_byte_strobe_pair[0], link.low_byte_strobe_pair[0]};
		end
	end
	// chip select high masks the command
	assign cmd = cmd_q[3] ? CMD_DES : cmd_q;
	// ----------------------------------------
	// burst control
	// ----------------------------------------
	sac_st_t                      st_q;
	logic [2:0]                   beat_q;
	logic [2:0]                   last_q;
	logic [BANK_W-1:0]            bb_q;
	logic [ROW_W-1:0]             brow_q;
	logic [2:0]                   bcol_q;
	logic                         bap_q;
	logic [BANKS-1:0]             row_open_q;
	logic [BANKS-1:0][ROW_W-1:0]  open_row_q;
	logic                         is_acc;
	logic                         start_rd;
	logic                         start_wr;
	logic                         burst_end;
	logic [MEM_AW-1:0]            acc_idx;
	assign is_acc    = (cmd == CMD_RD) || (cmd == CMD_WR);
	assign start_rd  = (st_q == ST_IDLE) && (cmd == CMD_RD) && row_open_q[ba_q];
	assign start_wr  = (st_q == ST_IDLE) && (cmd == CMD_WR) && row_open_q[ba_q];
	assign burst_end = (st_q != ST_IDLE) && (beat_q == last_q);
	// array location from open row and column
	assign acc_idx = {bb_q, brow_q[1:0], 3'(bcol_q + beat_q)};
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start_rd) begin
						st_q <= ST_RD;
					end else if (start_wr) begin
						st_q <= ST_WR;
					end
				end
				ST_WR, ST_RD: begin
					if (beat_q == last_q) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			beat_q <= '0;
		end else if (st_q == ST_IDLE) begin
			beat_q <= '0;
		end else begin
			beat_q <= 3'(beat_q + 1'b1);
		end
	end
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			last_q <= LAST_BL8;
			bb_q   <= '0;
			brow_q <= '0;
			bcol_q <= '0;
			bap_q  <= 1'b0;
		end else if (start_rd || start_wr) begin
			// bit 12 low means chopped burst
			last_q <= burst_last(!addr_q[BC_BIT]);
			// bank select names the target bank
			bb_q   <= ba_q;
			brow_q <= open_row_q[ba_q];
			// column from the low address bits
			bcol_q <= addr_q[2:0];
			bap_q  <= addr_q[AP_BIT];
		end
	end
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= (is_acc && !start_rd && !start_wr) ||
				((cmd == CMD_ACT) && row_open_q[ba_q]);
		end
	end
	// ----------------------------------------
	// bank and mode register state
	// ----------------------------------------
	logic [NUM_MR-1:0][ROW_W-1:0] mr_q;
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			row_open_q <= '0;
			open_row_q <= '0;
		end else begin
			// close bank at end of an auto-precharge burst
			if (burst_end && bap_q) begin
				row_open_q[bb_q] <= 1'b0;
			end
			case (cmd)
				CMD_ACT: begin
					if (!row_open_q[ba_q]) begin
						row_open_q[ba_q] <= 1'b1;
						open_row_q[ba_q] <= addr_q;
					end
				end
				CMD_PRE: begin
					// all banks or the selected one
					if (addr_q[AP_BIT]) begin
						row_open_q <= '0;
					end else begin
						row_open_q[ba_q] <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			mr_q <= '0;
		end else if ((cmd == CMD_MRS) && !ba_q[BANK_W-1]) begin
			mr_q[ba_q[MR_SEL_W-1:0]] <= addr_q;
		end
	end
	// ----------------------------------------
	// array and lane validity
	// ----------------------------------------
	logic [DQ_W-1:0]                  mem [MEM_DEPTH];
	logic [LANES-1:0][MEM_DEPTH-1:0]  lane_ok_q;
	logic [DQ_W-1:0]                  rdat_q;
	logic [LANES-1:0]                 rd_oe_q;
	logic [LANES-1:0]                 rd_stb_q;
	logic                             fault_q;
	always_ff @(posedge link.ck) begin
		for (int l = 0; l < LANES; l++) begin
			if ((st_q == ST_WR) && !mask_q[l]) begin
				mem[acc_idx][l*8 +: 8] <= wdat_q[l*8 +: 8];
			end
		end
	end
	// reset marks every stored byte as lost
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			lane_ok_q <= '0;
		end else begin
			for (int l = 0; l < LANES; l++) begin
				if ((st_q == ST_WR) && !mask_q[l]) begin
					lane_ok_q[l][acc_idx] <= 1'b1;
				end
			end
		end
	end
	// ----------------------------------------
	// read drive and strobes
	// ----------------------------------------
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			rdat_q   <= '0;
			rd_oe_q  <= '0;
			rd_stb_q <= '0;
		end else begin
			for (int l = 0; l < LANES; l++) begin
				if (st_q == ST_RD) begin
					rdat_q[l*8 +: 8] <= lane_ok_q[l][acc_idx] ? mem[acc_idx][l*8 +: 8] : 8'h00;
					rd_oe_q[l]       <= 1'b1;
					// strobe flips with the data edge
					rd_stb_q[l]      <= !rd_stb_q[l];
				end else begin
					rd_oe_q[l]  <= 1'b0;
					rd_stb_q[l] <= 1'b0;
				end
			end
		end
	end
	// each lane drives its own strobe pair
	assign link.dev_dq_o    = rdat_q;
	assign link.dev_dq_oe   = rd_oe_q;
	assign link.dev_dqs_o   = rd_stb_q;
	// complement always driven with the true side
	assign link.dev_dqs_n_o = ~rd_stb_q;
	// write strobe must be centred and differential
	always_ff @(posedge link.ck or negedge link.reset_n) begin
		if (!link.reset_n) begin
			fault_q <= 1'b0;
		end else if (st_q == ST_WR) begin
			for (int l = 0; l < LANES; l++) begin
				if ((wstb_t_q[l] == wstb_c_q[l]) || (wstb_t_q[l] == beat_q[0])) begin
					fault_q <= 1'b1;
				end
			end
		end
	end
	assign mode_regs    = mr_q;
	assign bank_open    = row_open_q;
	assign burst_busy   = st_q != ST_IDLE;
	assign strobe_fault = fault_q;
endmodule

// file: sac_mem_ctl.sv
// controller end: link clock divider, command issue, write fifo, read capture
`timescale 1ns/10ps
module sac_mem_ctl
	import sac_pkg::*;
(
	input  wire logic              clk,          // system clock
	input  wire logic              rst_n,        // async reset, active low
	sac_link_if.ctl                link,         // pin side
	input  wire logic              mem_reset,    // hold device in reset
	input  wire logic              cmd_valid,    // command offered
	output logic                   cmd_ready,    // command taken this edge
	input  wire sac_op_t           cmd_op,       // command kind
	input  wire logic [BANK_W-1:0] cmd_bank,     // bank or mode register
	input  wire logic [ROW_W-1:0]  cmd_addr,     // row, column or op-code
	input  wire logic              cmd_auto_pre, // auto-precharge or all banks
	input  wire logic              cmd_chop,     // chopped burst of four
	input  wire logic              wr_valid,     // write beat offered
	output logic                   wr_ready,     // write fifo has room
	input  wire logic [DQ_W-1:0]   wr_data,      // write beat data
	input  wire logic [LANES-1:0]  wr_mask,      // lane masks, high drops lane
	output logic                   rd_valid,     // pulse: read beat
	output logic [DQ_W-1:0]        rd_data,      // read beat data
	output logic                   busy          // burst in progress
);
	logic [1:0]              ph_q;
	logic                    ck_q;
	logic                    rstp_q;
	logic                    fall;
	logic                    rise;
	sac_st_t                 st_q;
	logic [3:0]              cnt_q;
	logic [3:0]              wait_q;
	logic [2:0]              last_q;
	logic [3:0]              pins_q;
	logic [BANK_W-1:0]       ba_q;
	logic [ROW_W-1:0]        addr_q;
	logic [ROW_W-1:0]        addr_d;
	logic [LANES-1:0]        mask_q;
	logic [DQ_W-1:0]         wdat_q;
	logic [LANES-1:0]        oe_q;
	logic [LANES-1:0]        stb_q;
	logic                    take;
	logic                    pop;
	logic                    f_valid;
	logic [DQ_W+LANES-1:0]   f_data;
	// ----------------------------------------
	// link clock divider and reset pin
	// ----------------------------------------
	assign fall = ph_q == PH_FALL;
	assign rise = ph_q == PH_RISE;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q   <= '0;
			ck_q   <= 1'b0;
			rstp_q <= 1'b0;
		end else begin
			ph_q   <= 2'(ph_q + 1'b1);
			ck_q   <= (ph_q == PH_RISE) || (ph_q < PH_FALL);
			// reset pin held high unless asked
			rstp_q <= !mem_reset;
		end
	end
	// ----------------------------------------
	// command issue at falling link clock
	// ----------------------------------------
	assign cmd_ready = (st_q == ST_IDLE) && fall && rstp_q && !mem_reset;
	assign take      = cmd_valid && cmd_ready;
	always_comb begin
		addr_d = '0;
		case (cmd_op)
			OP_RD, OP_WR: addr_d = {!cmd_chop, 1'b0, cmd_auto_pre, cmd_addr[COL_W-1:0]};
			OP_PRE: addr_d[AP_BIT] = cmd_auto_pre;
			default: addr_d = cmd_addr;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_q <= CMD_DES;
			ba_q   <= '0;
			addr_q <= '0;
		end else if (take) begin
			case (cmd_op)
				OP_ACT:  pins_q <= CMD_ACT;
				OP_RD:   pins_q <= CMD_RD;
				OP_WR:   pins_q <= CMD_WR;
				OP_PRE:  pins_q <= CMD_PRE;
				OP_MRS:  pins_q <= CMD_MRS;
				OP_REF:  pins_q <= CMD_REF;
				default: pins_q <= CMD_NOP;
			endcase
			ba_q   <= cmd_bank;
			addr_q <= addr_d;
		end else if (fall) begin
			pins_q <= CMD_DES;
		end
	end
	// ----------------------------------------
	// burst sequencing
	// ----------------------------------------
	logic [LANES-1:0] tog;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= ST_IDLE;
			cnt_q  <= '0;
			wait_q <= '0;
			last_q <= LAST_BL8;
		end else begin
			case (st_q)
				ST_IDLE: begin
					cnt_q  <= '0;
					wait_q <= '0;
					last_q <= burst_last(cmd_chop);
					if (take && (cmd_op == OP_WR)) begin
						st_q <= ST_WR;
					end else if (take && (cmd_op == OP_RD)) begin
						st_q <= ST_RD;
					end
				end
				ST_WR: begin
					if (fall && (cnt_q > {1'b0, last_q})) begin
						st_q <= ST_IDLE;
					end else if (fall) begin
						cnt_q <= 4'(cnt_q + 1'b1);
					end
				end
				ST_RD: begin
					if (rise && tog[0]) begin
						cnt_q <= 4'(cnt_q + 1'b1);
					end
					if (fall) begin
						wait_q <= 4'(wait_q + 1'b1);
					end
					if ((rise && tog[0] && (cnt_q == {1'b0, last_q})) ||
						(wait_q == RD_WAIT_CK)) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	assign busy = st_q != ST_IDLE;
	// ----------------------------------------
	// write data path
	// ----------------------------------------
	sac_fifo #(.W(DQ_W + LANES), .D(FIFO_DEPTH)) u_wfifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   ({wr_mask, wr_data}),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);
	assign pop = (st_q == ST_WR) && fall && (cnt_q <= {1'b0, last_q});
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_q   <= '0;
			stb_q  <= '0;
			wdat_q <= '0;
			mask_q <= '1;
		end else begin
			if (pop) begin
				oe_q   <= '1;
				wdat_q <= f_data[DQ_W-1:0];
				// empty fifo sends a masked beat
				mask_q <= f_valid ? f_data[DQ_W +: LANES] : '1;
			end else if (fall) begin
				oe_q   <= '0;
				mask_q <= '1;
			end
			if (rise && (oe_q != '0)) begin
				stb_q <= ~stb_q;
			end else if (oe_q == '0) begin
				stb_q <= '0;
			end
		end
	end
	// ----------------------------------------
	// read capture
	// ----------------------------------------
	logic [DQ_W-1:0]  dq_s1;
	logic [DQ_W-1:0]  dq_s2;
	logic [LANES-1:0] st_s1;
	logic [LANES-1:0] st_s2;
	logic [LANES-1:0] sc_s1;
	logic [LANES-1:0] sc_s2;
	logic [LANES-1:0] prev_q;
	logic [DQ_W-1:0]  rdat_q;
	logic             rval_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
			st_s1 <= '0;
			st_s2 <= '0;
			sc_s1 <= '1;
			sc_s2 <= '1;
		end else begin
			dq_s1 <= {link.high_data_byte, link.low_data_byte};
			dq_s2 <= dq_s1;
			st_s1 <= {link.high_byte_strobe_pair[1], link.low_byte_strobe_pair[1]};
			st_s2 <= st_s1;
			sc_s1 <= {link.high_byte_strobe_pair[0], link.low_byte_strobe_pair[0]};
			sc_s2 <= sc_s1;
		end
	end
	// a lane counts only on its own differential edge
	assign tog = (st_s2 ^ prev_q) & (st_s2 ^ sc_s2);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
			rdat_q <= '0;
			rval_q <= 1'b0;
		end else begin
			rval_q <= rise && (st_q == ST_RD) && tog[0];
			if (rise) begin
				prev_q <= st_s2;
				for (int l = 0; l < LANES; l++) begin
					if (tog[l]) begin
						rdat_q[l*8 +: 8] <= dq_s2[l*8 +: 8];
					end
				end
			end
		end
	end
	assign rd_valid              = rval_q;
	assign rd_data               = rdat_q;
	assign link.ck               = ck_q;
	assign link.reset_n          = rstp_q;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pins_q;
	assign link.bank_select      = ba_q;
	assign link.row_col_address  = addr_q;
	assign link.byte_write_masks = mask_q;
	assign link.ctl_dq_o         = wdat_q;
	assign link.ctl_dq_oe        = oe_q;
	assign link.ctl_dqs_o        = stb_q;
	assign link.ctl_dqs_n_o      = ~stb_q;
endmodule

// file: sac_link_checker.sv
// concurrent checks on the controller to device link
`timescale 1ns/10ps
module sac_link_checker
	import sac_pkg::*;
(
	input wire logic             ck,                   // link clock
	input wire logic             reset_n,              // device reset
	input wire logic             cs_n,                 // select
	input wire logic             ras_n,                // row strobe
	input wire logic             cas_n,                // column strobe
	input wire logic             we_n,                 // write enable
	input wire logic [LANES-1:0] byte_write_masks,     // lane masks
	input wire logic [LANES-1:0] ctl_dq_oe,            // ctl drive
	input wire logic [LANES-1:0] dev_dq_oe,            // dev drive
	input wire logic [LANES-1:0] ctl_dqs_o,            // ctl strobe
	input wire logic [LANES-1:0] dev_dqs_o,            // dev strobe
	input wire logic [1:0]       low_byte_strobe_pair, // low pair
	input wire logic [1:0]       high_byte_strobe_pair // high pair
);
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	default clocking cb @(posedge ck); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// link checks
	// ----------------------------------------
	cmp_low_a: assert property ((dev_dq_oe[0] | ctl_dq_oe[0]) |-> ^low_byte_strobe_pair)
		else $error("low pair not complementary");
	cmp_high_a: assert property ((dev_dq_oe[1] | ctl_dq_oe[1]) |-> ^high_byte_strobe_pair)
		else $error("high pair not complementary");
	one_driver_a: assert property ((dev_dq_oe & ctl_dq_oe) == 2'h0)
		else $error("both ends drive a lane");
	rd_align_a: assert property (dev_dq_oe == 2'h3 && $past(dev_dq_oe) == 2'h3
		|-> dev_dqs_o == ~$past(dev_dqs_o)) else $error("read strobe not aligned");
	wr_center_a: assert property (@(negedge ck) ctl_dq_oe == 2'h3 && $past(ctl_dq_oe) == 2'h3
		|-> ctl_dqs_o == ~$past(ctl_dqs_o)) else $error("write strobe not centred");
	rd_lat_a: assert property ($rose(dev_dq_oe[0]) |-> $past(cmd, 3) == CMD_RD)
		else $error("read data without read");
	wr_lat_a: assert property ($rose(ctl_dq_oe[0]) |-> $past(cmd) == CMD_WR)
		else $error("write data without write");
	mask_idle_a: assert property (ctl_dq_oe == 2'h0 |-> byte_write_masks == 2'h3)
		else $error("mask low while not writing");
	cover property (cmd == CMD_MRS);
	cover property (cmd == CMD_WR);
	cover property (cmd == CMD_RD);
endmodule

// file: sdram_addr_ctrl_strobe_pins_tb_top.sv
// self-checking bench joining controller and device ends
`timescale 1ns/10ps
module sdram_addr_ctrl_strobe_pins_tb_top;
	import sac_pkg::*;
	logic                 clk = 1'b0, rst_n = 1'b0, mem_reset = 1'b0, cmd_valid = 1'b0;
	logic                 cmd_auto_pre = 1'b0, cmd_chop = 1'b0, wr_valid = 1'b0, ap, rc;
	logic                 cmd_ready, wr_ready, rd_valid, busy, burst_busy, cmd_refused, strobe_fault;
	sac_op_t              cmd_op = OP_NOP;
	logic [2:0]           cmd_bank = 3'h0, b;
	logic [12:0]          cmd_addr = 13'h0, r;
	logic [9:0]           c;
	logic [15:0]          wr_data = 16'h0, rd_data, v, exp_mem [256];
	logic [1:0]           wr_mask = 2'h0;
	logic [7:0]           bank_open;
	logic [3:0][12:0]     mode_regs;
	int                   n_mismatch = 0, checks_done = 0, seed = 53, i, j;
	always #2 clk = ~clk;
	sac_link_if u_sac_link_if ();
	sac_mem_dev u_sac_mem_dev (.link(u_sac_link_if), .mode_regs, .bank_open, .burst_busy,
		.cmd_refused, .strobe_fault);
	sac_mem_ctl u_sac_mem_ctl (.clk, .rst_n, .link(u_sac_link_if), .mem_reset, .cmd_valid,
		.cmd_ready, .cmd_op, .cmd_bank, .cmd_addr, .cmd_auto_pre, .cmd_chop, .wr_valid,
		.wr_ready, .wr_data, .wr_mask, .rd_valid, .rd_data, .busy);
	sac_link_checker u_sac_link_checker (.ck(u_sac_link_if.ck), .reset_n(u_sac_link_if.reset_n),
		.cs_n(u_sac_link_if.cs_n), .ras_n(u_sac_link_if.ras_n), .cas_n(u_sac_link_if.cas_n),
		.we_n(u_sac_link_if.we_n), .byte_write_masks(u_sac_link_if.byte_write_masks),
		.ctl_dq_oe(u_sac_link_if.ctl_dq_oe), .dev_dq_oe(u_sac_link_if.dev_dq_oe),
		.ctl_dqs_o(u_sac_link_if.ctl_dqs_o), .dev_dqs_o(u_sac_link_if.dev_dqs_o),
		.low_byte_strobe_pair(u_sac_link_if.low_byte_strobe_pair),
		.high_byte_strobe_pair(u_sac_link_if.high_byte_strobe_pair));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic int idx(input int k);
		return {b, r[1:0], 3'(c[2:0] + k)};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic issue(input sac_op_t op, input logic [2:0] bk, input logic [12:0] a,
		input logic p, input logic ch);
		@(posedge clk);
		{cmd_valid, cmd_op, cmd_bank, cmd_addr, cmd_auto_pre, cmd_chop} <= {1'b1, op, bk, a, p, ch};
		@(negedge clk);
		for (int k = 0; k < 80 && cmd_ready !== 1'b1; k++) @(negedge clk);
		chk(16'(cmd_ready), 16'h1);
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic beat(input int k);
		logic [15:0] d;
		logic [1:0]  m;
		d = 16'($random(seed));
		m = 2'($random(seed));
		if (!m[0]) exp_mem[idx(k)][7:0] = d[7:0];
		if (!m[1]) exp_mem[idx(k)][15:8] = d[15:8];
		@(posedge clk);
		{wr_valid, wr_data, wr_mask} <= {1'b1, d, m};
		@(negedge clk);
		for (int q = 0; q < 80 && wr_ready !== 1'b1; q++) @(negedge clk);
		chk(16'(wr_ready), 16'h1);
		@(posedge clk);
		wr_valid <= 1'b0;
	endtask
	task automatic collect(input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge clk);
			for (int q = 0; q < 80 && rd_valid !== 1'b1; q++) @(negedge clk);
			chk(16'(rd_valid), 16'h1);
			chk(rd_data, exp_mem[idx(k)]);
		end
		repeat (16) begin
			@(negedge clk);
			chk(16'(rd_valid), 16'h0);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial begin
		for (i = 0; i < 256; i++) exp_mem[i] = 16'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			issue(OP_MRS, 3'(i), v[12:0], 1'b0, 1'b0);
			issue(OP_MRS, 3'(i + 4), ~v[12:0], 1'b0, 1'b0);
			repeat (16) @(posedge clk);
			chk(16'(mode_regs[i]), {3'h0, v[12:0]});
		end
		for (i = 0; i < 6; i++) begin
			{b, r, c, rc} = 27'($random(seed));
			ap = i[1];
			issue(OP_ACT, b, r, 1'b0, 1'b0);
			for (j = 0; j < 4; j++) beat(j);
			@(negedge clk);
			chk(16'(wr_ready), 16'h0);
			fork
				issue(OP_WR, b, {3'h0, c}, 1'b0, i[0]);
				for (j = 4; j < (i[0] ? 4 : 8); j++) beat(j);
			join
			issue(OP_RD, b, {3'h0, c}, ap, rc);
			collect(rc ? 4 : 8);
			chk(16'({busy, burst_busy}), 16'h0);
			chk(16'(bank_open[b]), 16'(!ap));
			if (!ap) issue(OP_PRE, b, 13'h0, 1'b0, 1'b0);
		end
		issue(OP_ACT, 3'h1, 13'h5, 1'b0, 1'b0);
		issue(OP_ACT, 3'h2, 13'h6, 1'b0, 1'b0);
		issue(OP_ACT, 3'h2, 13'h7, 1'b0, 1'b0);
		repeat (7) @(posedge clk);
		chk(16'(cmd_refused), 16'h1);
		issue(OP_REF, 3'h0, 13'h0, 1'b0, 1'b0);
		issue(OP_PRE, 3'h1, 13'h0, 1'b0, 1'b0);
		repeat (16) @(posedge clk);
		chk(16'(bank_open), 16'h0004);
		issue(OP_ACT, b, r, 1'b0, 1'b0);
		issue(OP_PRE, 3'h5, 13'h0, 1'b1, 1'b0);
		repeat (16) @(posedge clk);
		chk(16'(bank_open), 16'h0);
		issue(OP_ACT, b, r, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk(16'(bank_open[b]), 16'h1);
		mem_reset <= 1'b1;
		repeat (8) @(posedge clk);
		chk(16'(bank_open), 16'h0);
		chk(16'(mode_regs[1]), 16'h0);
		mem_reset <= 1'b0;
		for (i = 0; i < 256; i++) exp_mem[i] = 16'h0;
		issue(OP_ACT, b, r, 1'b0, 1'b0);
		issue(OP_RD, b, {3'h0, c}, 1'b1, 1'b0);
		collect(8);
		chk(16'(strobe_fault), 16'h0);
		conclude();
	end
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
endmodule
